// ==== core/pwmflt_pkg.sv ====
package pwmflt_pkg;

	// Register byte offsets (one aligned 32-bit word each)
	localparam logic [3:0] OFS_GEN_CTRL = 4'h0;
	localparam logic [3:0] OFS_FAULT_CFG = 4'h4;
	localparam logic [3:0] OFS_OUT_CTRL = 4'h8;
	localparam logic [3:0] OFS_PRI_TB_CTRL = 4'hC;
	localparam int ADDR_W = 4;

	// generator_control_reg fields
	localparam int GC_FAULT_STATUS = 15;
	localparam int GC_CLIM_STATUS = 14;
	localparam int GC_TRIG_STATUS = 13;
	localparam int GC_FAULT_IRQ_EN = 12;
	localparam int GC_CLIM_IRQ_EN = 11;
	localparam int GC_TRIG_IRQ_EN = 10;
	localparam int GC_PWM_ENABLE = 0;

	// fault_limit_config_reg fields
	localparam int FC_SRC_LSB = 3;
	localparam int FC_SRC_W = 5;
	localparam int FC_POL = 2;
	localparam int FC_MODE_LSB = 0;
	localparam int FC_MODE_W = 2;

	// output_control_reg fields
	localparam int OC_FAULT_DATA_LSB = 4;
	localparam int OC_CLIM_DATA_LSB = 2;

	// primary_timebase_control_reg fields
	localparam int PT_SPECIAL_IRQ_EN = 11;

	localparam int FAULT_PINS = 8;
	localparam int MAP_W = 7;
	localparam logic [6:0] MAP_COMPARATOR1 = 7'h01;

	typedef enum logic [1:0] {
		PWMFLT_MODE_LATCHED = 2'h0,
		PWMFLT_MODE_CYCLE = 2'h1,
		PWMFLT_MODE_RSVD = 2'h2,
		PWMFLT_MODE_OFF = 2'h3
	} pwmflt_mode_t;

	// Safety-class fault comes up latched on the selected source
	localparam logic [1:0] RST_FAULT_MODE = 2'h0;
	localparam logic [4:0] RST_FAULT_SRC = 5'h00;

	typedef struct packed {
		logic [1:0] fault_override_values;
		logic [1:0] clim_override_values;
	} pwmflt_out_ctrl_t;

	typedef struct packed {
		logic [4:0] fault_source_select;
		logic fault_polarity;
		logic [1:0] fault_mode_select;
	} pwmflt_fault_cfg_t;

	typedef struct packed {
		logic high_side_output;
		logic low_side_output;
	} pwmflt_pair_t;

endpackage : pwmflt_pkg

// ==== core/pwmflt_gen.sv ====
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// What this block does, and what software must do (R19, R21)
// [R1] Generator IRQ ORs trigger, limit, fault
// [R2] Special-event IRQ gated by enable bit 11
// [R3] Trigger IRQ gated by enable bit 10
// [R4] ADC triggers always emitted on match
// [R5] Any enabled source raises generator flag
// [R6] Separate trigger, fault, limit status bits
// [R7] Five-bit fault source select, bits 7:3
// [R8] Fault IRQ enable bit 12, override-independent
// [R9] Polarity bit 2 makes input active-low
// [R10] Override values bits 5:4, zero immediate
// [R11] Selected fault also triggers ADC always
// [R12] Status shows latch or live level
// [R13] Latched exit: input gone, flag cleared
// [R14] Cleared early: hold until input released
// [R15] Clearing fault IRQ enable clears status
// [R16] Cycle mode: override values driven during fault
// [R17] Fault mode field at bits 1:0
// [R18] Reset enables fault in latched mode
// [R19] Software clears safety fault before enabling
// [R20] Map value 1 routes comparator 1
// [R21] Software clears flags, enables, then starts
// [R22] Fault pins readable while module enabled
// [R23] Fault override beats current-limit override
// [R24] Cycle mode clears itself each cycle
// [R25] Two-flop synchroniser; zero path bypasses
module pwmflt_gen #(
	parameter int NPINS = pwmflt_pkg::FAULT_PINS
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [pwmflt_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	input wire logic [NPINS-1:0] fault_input_pin_i,
	input wire logic comparator1_output_i,
	input wire logic [pwmflt_pkg::MAP_W-1:0] fault1_input_map_i,
	input wire logic trigger_match_i,
	input wire logic special_event_match_i,
	input wire logic cycle_start_i,
	input wire logic clim_active_i,
	input wire logic clim_irq_req_i,
	input wire pwmflt_pkg::pwmflt_pair_t pwm_normal_i,
	input wire logic [1:0] deadtime_override_i,
	output pwmflt_pkg::pwmflt_pair_t pwm_out_o,
	output logic [1:0] deadtime_request_o,
	output logic gen_irq_o,
	output logic special_irq_o,
	output logic adc_trigger_o,
	output logic adc_special_trigger_o,
	output logic adc_fault_trigger_o,
	output logic [NPINS-1:0] fault_pin_levels_o
);

	typedef struct packed {
		logic [1:0] sync_ff;
		logic fault_latch;
		logic trig_latch;
		logic override_on;
		logic fault_irq_en;
		logic clim_irq_en;
		logic trig_irq_en;
		logic pwm_enable;
		logic special_irq_en;
		pwmflt_pkg::pwmflt_fault_cfg_t fcfg;
		pwmflt_pkg::pwmflt_out_ctrl_t octl;
		logic [31:0] rdata;
		logic ack;
		logic trig_pulse;
		logic special_pulse;
		logic special_irq;
		logic gen_irq;
		logic [NPINS-1:0] pins;
	} pwmflt_state_t;

	pwmflt_state_t s_q, s_d;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	logic [NPINS-1:0] src_vec;
	logic raw_sel;
	logic fault_live;
	logic fault_sync;
	logic mode_latched;
	logic mode_cycle;
	logic fault_event;
	logic [31:0] gc_view;
	logic [31:0] fc_view;
	logic [31:0] oc_view;
	logic [31:0] pt_view;
	logic bus_req;
	logic [31:0] wm;

	// [R20] comparator routing
	always_comb begin
		src_vec = fault_input_pin_i;
		if (fault1_input_map_i == pwmflt_pkg::MAP_COMPARATOR1) begin
			src_vec[0] = comparator1_output_i;
		end
	end

	// [R7] source select
	always_comb begin
		raw_sel = 1'b0;
		if (s_q.fcfg.fault_source_select < 5'(NPINS)) begin
			raw_sel = src_vec[s_q.fcfg.fault_source_select[2:0]];
		end
	end

	// [R9] polarity
	assign fault_live = raw_sel ^ s_q.fcfg.fault_polarity;
	// [R25] synchronised copy
	assign fault_sync = s_q.sync_ff[1] ^ s_q.fcfg.fault_polarity;
	// [R17] mode decode
	assign mode_latched = s_q.fcfg.fault_mode_select == 2'(pwmflt_pkg::PWMFLT_MODE_LATCHED);
	assign mode_cycle = s_q.fcfg.fault_mode_select == 2'(pwmflt_pkg::PWMFLT_MODE_CYCLE);
	assign fault_event = fault_sync;

	// [R6] status bits; [R12] latch or live level
	always_comb begin
		gc_view = '0;
		gc_view[pwmflt_pkg::GC_FAULT_STATUS] = s_q.fault_irq_en ? s_q.fault_latch : fault_sync;
		gc_view[pwmflt_pkg::GC_CLIM_STATUS] = clim_active_i;
		gc_view[pwmflt_pkg::GC_TRIG_STATUS] = s_q.trig_latch;
		gc_view[pwmflt_pkg::GC_FAULT_IRQ_EN] = s_q.fault_irq_en;
		gc_view[pwmflt_pkg::GC_CLIM_IRQ_EN] = s_q.clim_irq_en;
		gc_view[pwmflt_pkg::GC_TRIG_IRQ_EN] = s_q.trig_irq_en;
		gc_view[pwmflt_pkg::GC_PWM_ENABLE] = s_q.pwm_enable;
		fc_view = '0;
		fc_view[pwmflt_pkg::FC_SRC_LSB +: pwmflt_pkg::FC_SRC_W] = s_q.fcfg.fault_source_select;
		fc_view[pwmflt_pkg::FC_POL] = s_q.fcfg.fault_polarity;
		fc_view[pwmflt_pkg::FC_MODE_LSB +: pwmflt_pkg::FC_MODE_W] = s_q.fcfg.fault_mode_select;
		oc_view = '0;
		oc_view[pwmflt_pkg::OC_FAULT_DATA_LSB +: 2] = s_q.octl.fault_override_values;
		oc_view[pwmflt_pkg::OC_CLIM_DATA_LSB +: 2] = s_q.octl.clim_override_values;
		pt_view = '0;
		pt_view[pwmflt_pkg::PT_SPECIAL_IRQ_EN] = s_q.special_irq_en;
	end

	assign bus_req = (avs_read_i | avs_write_i) & ~s_q.ack;

	always_comb begin
		s_d = s_q;
		wm = '0;
		s_d.ack = bus_req;
		s_d.sync_ff = {s_q.sync_ff[0], raw_sel};
		s_d.pins = fault_input_pin_i;
		// [R4] ADC pulses regardless of enables
		s_d.trig_pulse = trigger_match_i;
		s_d.special_pulse = special_event_match_i;
		if (bus_req && avs_read_i) begin
			unique case (avs_address_i)
				pwmflt_pkg::OFS_GEN_CTRL: s_d.rdata = gc_view;
				pwmflt_pkg::OFS_FAULT_CFG: s_d.rdata = fc_view;
				pwmflt_pkg::OFS_OUT_CTRL: s_d.rdata = oc_view;
				pwmflt_pkg::OFS_PRI_TB_CTRL: s_d.rdata = pt_view;
				default: s_d.rdata = '0;
			endcase
		end
		if (bus_req && avs_write_i) begin
			unique case (avs_address_i)
				pwmflt_pkg::OFS_GEN_CTRL: begin
					wm = wmerge(gc_view, avs_writedata_i, avs_byteenable_i);
					s_d.fault_irq_en = wm[pwmflt_pkg::GC_FAULT_IRQ_EN];
					s_d.clim_irq_en = wm[pwmflt_pkg::GC_CLIM_IRQ_EN];
					s_d.trig_irq_en = wm[pwmflt_pkg::GC_TRIG_IRQ_EN];
					s_d.pwm_enable = wm[pwmflt_pkg::GC_PWM_ENABLE];
					// [R15] disabling clears status latch
					if (!wm[pwmflt_pkg::GC_FAULT_IRQ_EN]) begin
						s_d.fault_latch = 1'b0;
					end
					if (!wm[pwmflt_pkg::GC_TRIG_IRQ_EN]) begin
						s_d.trig_latch = 1'b0;
					end
				end
				pwmflt_pkg::OFS_FAULT_CFG: begin
					wm = wmerge(fc_view, avs_writedata_i, avs_byteenable_i);
					s_d.fcfg.fault_source_select = wm[pwmflt_pkg::FC_SRC_LSB +: pwmflt_pkg::FC_SRC_W];
					s_d.fcfg.fault_polarity = wm[pwmflt_pkg::FC_POL];
					s_d.fcfg.fault_mode_select = wm[pwmflt_pkg::FC_MODE_LSB +: pwmflt_pkg::FC_MODE_W];
				end
				pwmflt_pkg::OFS_OUT_CTRL: begin
					wm = wmerge(oc_view, avs_writedata_i, avs_byteenable_i);
					s_d.octl.fault_override_values = wm[pwmflt_pkg::OC_FAULT_DATA_LSB +: 2];
					s_d.octl.clim_override_values = wm[pwmflt_pkg::OC_CLIM_DATA_LSB +: 2];
				end
				pwmflt_pkg::OFS_PRI_TB_CTRL: begin
					wm = wmerge(pt_view, avs_writedata_i, avs_byteenable_i);
					// [R2] special-event enable
					s_d.special_irq_en = wm[pwmflt_pkg::PT_SPECIAL_IRQ_EN];
				end
				default: begin
				end
			endcase
		end
		// [R8] latch set gated by enable only, clear wins over set
		if (fault_event && s_d.fault_irq_en) begin
			s_d.fault_latch = 1'b1;
		end
		// [R3] trigger request gated
		if (trigger_match_i && s_d.trig_irq_en) begin
			s_d.trig_latch = 1'b1;
		end
		// [R13] [R14] [R16] [R24] override entry and cycle-boundary exit
		if (fault_sync && (mode_latched || mode_cycle)) begin
			s_d.override_on = 1'b1;
		end else if (s_q.override_on && cycle_start_i) begin
			if (mode_cycle || !mode_latched) begin
				s_d.override_on = 1'b0;
			end else if (!s_q.fault_latch || !s_q.fault_irq_en) begin
				s_d.override_on = 1'b0;
			end
		end
		// [R1] [R5] one request per generator
		s_d.gen_irq = s_d.fault_latch | s_d.trig_latch | (clim_irq_req_i & s_d.clim_irq_en);
		s_d.special_irq = special_event_match_i & s_d.special_irq_en;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '0;
			// [R18] latched safety fault at reset
			s_q.fcfg.fault_mode_select <= pwmflt_pkg::RST_FAULT_MODE;
			s_q.fcfg.fault_source_select <= pwmflt_pkg::RST_FAULT_SRC;
		end else begin
			s_q <= s_d;
		end
	end

	// [R10] [R23] output override; zero values bypass synchroniser
	always_comb begin
		pwm_out_o = pwm_normal_i;
		deadtime_request_o = 2'h0;
		if (clim_active_i) begin
			pwm_out_o = s_q.octl.clim_override_values;
		end
		// [R16] both modes hold override values
		// Fault assignments come last so a fault beats the limit
		if (s_q.override_on || ((mode_latched || mode_cycle) && fault_live)) begin
			deadtime_request_o = s_q.octl.fault_override_values;
			pwm_out_o.high_side_output = s_q.octl.fault_override_values[1] & deadtime_override_i[1];
			pwm_out_o.low_side_output = s_q.octl.fault_override_values[0] & deadtime_override_i[0];
		end
	end

	assign avs_waitrequest_o = bus_req;
	assign avs_readdata_o = s_q.rdata;
	assign avs_response_o = 2'h0;
	assign gen_irq_o = s_q.gen_irq;
	assign special_irq_o = s_q.special_irq;
	assign adc_trigger_o = s_q.trig_pulse;
	assign adc_special_trigger_o = s_q.special_pulse;
	// [R11] ADC fault trigger always live
	assign adc_fault_trigger_o = fault_sync;
	// [R22] pin levels for polling
	assign fault_pin_levels_o = s_q.pins;

endmodule : pwmflt_gen

// ==== sim/pwmflt_checker.sv ====
`timescale 1ns/1ns
module pwmflt_checker #(
	parameter int NPINS = 8
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] avs_response_o,
	input wire logic [NPINS-1:0] fault_input_pin_i,
	input wire logic [NPINS-1:0] fault_pin_levels_o,
	input wire logic trigger_match_i,
	input wire logic special_event_match_i,
	input wire logic special_irq_o,
	input wire logic adc_trigger_o,
	input wire logic adc_special_trigger_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	property p_adc_trig; trigger_match_i |=> adc_trigger_o; endproperty
	a_adc_trig: assert property (p_adc_trig) else $error("adc trigger missing");
	property p_adc_trig_src; adc_trigger_o |-> $past(trigger_match_i); endproperty
	a_adc_trig_src: assert property (p_adc_trig_src) else $error("adc trigger unprompted");
	property p_adc_sev; special_event_match_i |=> adc_special_trigger_o; endproperty
	a_adc_sev: assert property (p_adc_sev) else $error("special trigger missing");
	property p_adc_sev_src; adc_special_trigger_o |-> $past(special_event_match_i); endproperty
	a_adc_sev_src: assert property (p_adc_sev_src) else $error("special trigger unprompted");
	property p_sev_irq; special_irq_o |-> $past(special_event_match_i); endproperty
	a_sev_irq: assert property (p_sev_irq) else $error("special irq without match");
	property p_pins; fault_pin_levels_o == $past(fault_input_pin_i); endproperty
	a_pins: assert property (p_pins) else $error("pin copy wrong");
	property p_resp; avs_response_o == 2'h0; endproperty
	a_resp: assert property (p_resp) else $error("response not okay");
	property p_wait; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
	a_wait: assert property (p_wait) else $error("waitrequest timing wrong");
endmodule : pwmflt_checker
bind pwmflt_gen pwmflt_checker #(.NPINS(NPINS)) u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.avs_response_o(avs_response_o), .fault_input_pin_i(fault_input_pin_i),
	.fault_pin_levels_o(fault_pin_levels_o), .trigger_match_i(trigger_match_i),
	.special_event_match_i(special_event_match_i), .special_irq_o(special_irq_o),
	.adc_trigger_o(adc_trigger_o), .adc_special_trigger_o(adc_special_trigger_o));

// ==== sim/pwmflt_partner.sv ====
`timescale 1ns/1ns
module pwmflt_partner (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic gen_irq_i,
	input wire logic special_irq_i,
	input wire logic flag_clear_i,
	output logic irq_flag_o,
	output int sev_count_o
);
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_flag_o <= 1'b0;
			sev_count_o <= 0;
		end else begin
			if (gen_irq_i)
				irq_flag_o <= 1'b1;
			else if (flag_clear_i)
				irq_flag_o <= 1'b0;
			if (special_irq_i)
				sev_count_o <= sev_count_o + 1;
		end
	end
endmodule : pwmflt_partner

// ==== sim/tb_pwmflt_gen.sv ====
`timescale 1ns/1ns
module tb_pwmflt_gen;
	logic clk_sys_i = 0, nrst_i = 0, rd = 0, wr = 0, tm = 0, sm = 0, cs = 0, ca = 0, cr = 0, cmp = 0, clr = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdata;
	logic [7:0] pins = 8'h00, lv;
	logic [6:0] map = 7'h00;
	logic [1:0] dt = 2'h0, resp, dreq;
	logic wq, irq, sirq, at, ast, af, flag;
	pwmflt_pkg::pwmflt_pair_t nrm = 2'h0, pout;
	int sev, n_errors = 0, total_checks = 0, cnt = 0;
	logic [31:0] exp_q[$];
	always #2 clk_sys_i = ~clk_sys_i;
	pwmflt_gen dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wq), .avs_response_o(resp), .fault_input_pin_i(pins),
		.comparator1_output_i(cmp), .fault1_input_map_i(map), .trigger_match_i(tm),
		.special_event_match_i(sm), .cycle_start_i(cs), .clim_active_i(ca), .clim_irq_req_i(cr),
		.pwm_normal_i(nrm), .deadtime_override_i(dt), .pwm_out_o(pout), .deadtime_request_o(dreq),
		.gen_irq_o(irq), .special_irq_o(sirq), .adc_trigger_o(at), .adc_special_trigger_o(ast),
		.adc_fault_trigger_o(af), .fault_pin_levels_o(lv));
	pwmflt_partner u_ic (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .gen_irq_i(irq), .special_irq_i(sirq),
		.flag_clear_i(clr), .irq_flag_o(flag), .sev_count_o(sev));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (e !== s) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : cyc
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk_sys_i); while (wq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rdc
	task automatic pulse_cs();
		@(posedge clk_sys_i) cs <= 1'b1;
		@(posedge clk_sys_i) cs <= 1'b0;
		cyc(2);
	endtask : pulse_cs
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys_i) begin
		if (rd && wq === 1'b0)
			chk("rdata", exp_q.pop_front(), rdata);
		cnt++;
		if (cnt == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(75556));
		cyc(4);
		nrst_i <= 1'b1;
		// High side forced on so normal never looks like an override
		nrm <= 2'($urandom) | 2'h2;
		dt <= 2'($urandom) | 2'h1;
		for (int i = 0; i < 4; i++)
			rdc(4'(i * 4), 32'h0);
		// Unmapped offset: writes dropped
		bus(1'b1, 4'h2, 32'hFFFFFFFF);
		rdc(4'h2, 32'h0);
		pins <= 8'h01;
		cyc(5);
		chk("rst_ovr", 32'h0, 32'(pout));
		pins <= 8'h00;
		cyc(5);
		chk("rst_hold", 32'h0, 32'(pout));
		pulse_cs();
		chk("rst_exit", 32'(nrm), 32'(pout));
		for (int i = 0; i < 8; i++)
			for (int p = 0; p < 2; p++) begin
				bus(1'b1, 4'h4, 32'({5'(i), 1'(p), 2'h3}));
				pins <= 8'($urandom) | (8'h01 << i);
				cyc(5);
				chk("adc_flt", 32'(p == 0), 32'(af));
				rdc(4'h0, (p == 0) ? 32'h8000 : 32'h0);
			end
		pins <= 8'h00;
		map <= 7'h01;
		cmp <= 1'b1;
		bus(1'b1, 4'h4, 32'h3);
		cyc(5);
		chk("cmp", 32'h1, 32'(af));
		cmp <= 1'b0;
		map <= 7'h00;
		bus(1'b1, 4'h8, 32'h0);
		clr <= 1'b1;
		cyc(1);
		clr <= 1'b0;
		bus(1'b1, 4'h0, 32'h1000);
		bus(1'b1, 4'h0, 32'h1001);
		bus(1'b1, 4'h4, 32'h18);
		pins <= 8'h08;
		cyc(1);
		// Zero override must land before the synchroniser settles
		chk("ovr_now", 32'h0, 32'(pout));
		cyc(4);
		chk("irq", 32'h1, 32'(irq));
		chk("flag", 32'h1, 32'(flag));
		chk("ovr", 32'h0, 32'(pout));
		rdc(4'h0, 32'h9001);
		bus(1'b1, 4'h0, 32'h1);
		cyc(3);
		chk("irq_clr", 32'h0, 32'(irq));
		pulse_cs();
		chk("held", 32'h0, 32'(pout));
		pins <= 8'h00;
		cyc(5);
		chk("wait_edge", 32'h0, 32'(pout));
		pulse_cs();
		chk("resume", 32'(nrm), 32'(pout));
		bus(1'b1, 4'h8, 32'h18);
		ca <= 1'b1;
		bus(1'b1, 4'h4, 32'h19);
		pins <= 8'h08;
		cyc(5);
		chk("cbc", 32'({1'b0, dt[0]}), 32'(pout));
		chk("dt_req", 32'h1, 32'(dreq));
		pins <= 8'h00;
		ca <= 1'b0;
		cyc(5);
		chk("cbc_hold", 32'({1'b0, dt[0]}), 32'(pout));
		pulse_cs();
		chk("cbc_exit", 32'(nrm), 32'(pout));
		@(posedge clk_sys_i) tm <= 1'b1;
		@(posedge clk_sys_i) tm <= 1'b0;
		cyc(3);
		chk("trg_off", 32'h0, 32'(irq));
		bus(1'b1, 4'h0, 32'h0401);
		@(posedge clk_sys_i) tm <= 1'b1;
		@(posedge clk_sys_i) tm <= 1'b0;
		cyc(3);
		chk("trg_on", 32'h1, 32'(irq));
		rdc(4'h0, 32'h2401);
		bus(1'b1, 4'h0, 32'h0801);
		cr <= 1'b1;
		cyc(4);
		chk("clim", 32'h1, 32'(irq));
		cr <= 1'b0;
		@(posedge clk_sys_i) sm <= 1'b1;
		@(posedge clk_sys_i) sm <= 1'b0;
		bus(1'b1, 4'hC, 32'h800);
		@(posedge clk_sys_i) sm <= 1'b1;
		@(posedge clk_sys_i) sm <= 1'b0;
		cyc(3);
		chk("sev", 32'h1, 32'(sev));
		bus(1'b1, 4'h4, 32'h1B);
		bus(1'b1, 4'h0, 32'h1001);
		pins <= 8'h08;
		cyc(5);
		chk("irq_nomode", 32'h1, 32'(irq));
		chk("no_ovr", 32'(nrm), 32'(pout));
		report_and_stop();
	end
endmodule : tb_pwmflt_gen
